//--- common/supervisor_pkg.sv
// supervisor_pkg: constants, register map and types for the supply supervisor
// assumes a 125 MHz core clock and a 12-bit APB byte address
package supervisor_pkg;

   // core clock rate, in kHz so that millisecond figures convert exactly
   localparam int unsigned CORE_CLK_KHZ = 125000;

   // internal-timebase intervals as printed, in ms
   localparam int unsigned HOLD_SHORT_MS = 50;
   localparam int unsigned HOLD_LONG_MS  = 200;
   localparam int unsigned WDOG_SHORT_MS = 100;
   localparam int unsigned WDOG_LONG_MS  = 1600;

   // the same intervals in core cycles (all exact, so no rounding needed)
   localparam logic [31:0] HOLD_SHORT_CYC = 32'(HOLD_SHORT_MS * CORE_CLK_KHZ);
   localparam logic [31:0] HOLD_LONG_CYC  = 32'(HOLD_LONG_MS * CORE_CLK_KHZ);
   localparam logic [31:0] WDOG_SHORT_CYC = 32'(WDOG_SHORT_MS * CORE_CLK_KHZ);
   localparam logic [31:0] WDOG_LONG_CYC  = 32'(WDOG_LONG_MS * CORE_CLK_KHZ);

   // external-timebase counts, in rising edges of the timebase clock
   localparam logic [31:0] EXT_WDOG_LONG_TICKS  = 32'h0000_1000;
   localparam logic [31:0] EXT_WDOG_SHORT_TICKS = 32'h0000_0400;
   localparam logic [31:0] EXT_HOLD_TICKS       = 32'h0000_0100;

   // apb map
   localparam int unsigned APB_AW     = 12;
   localparam logic [11:0] CTRL_OFS   = 12'h000;
   localparam logic [11:0] STATUS_OFS = 12'h004;

   // control register fields and reset values
   localparam int unsigned CTRL_LONG_HOLD_BIT = 0;
   localparam int unsigned CTRL_WDOG_SHORT_BIT = 1;
   localparam logic [1:0]  CTRL_RST           = 2'h0;

   // status register fields
   localparam int unsigned ST_RESET_BIT    = 0;
   localparam int unsigned ST_WDOG_TO_BIT  = 1;
   localparam int unsigned ST_STROBE_MID   = 2;
   localparam int unsigned ST_BACKUP_BIT   = 3;
   localparam int unsigned ST_EXT_TB_BIT   = 4;
   localparam int unsigned ST_PF_WARN_BIT  = 5;
   localparam int unsigned ST_STROBE_LVL   = 6;

   // positions of the pin inputs in the synchroniser vector
   localparam int unsigned NPINS          = 8;
   localparam int unsigned PIN_SUPPLY_LOW = 0;
   localparam int unsigned PIN_BELOW_BATT = 1;
   localparam int unsigned PIN_PF_COMPARE = 2;
   localparam int unsigned PIN_STROBE     = 3;
   localparam int unsigned PIN_STROBE_MID = 4;
   localparam int unsigned PIN_CE_N       = 5;
   localparam int unsigned PIN_TB_SEL     = 6;
   localparam int unsigned PIN_TB_CLK     = 7;
   // safe idle pin values: supply low, strobe floating, chip select off
   localparam logic [7:0]  PIN_RST        = 8'h75;

   // power-on / watchdog reset sequencer
   typedef enum logic [1:0] {
      RS_POWER_BAD,
      RS_HOLD,
      RS_RUN
   } rst_state_e;

endpackage

//--- rtl/supply_supervisor_watchdog.sv
// supply_supervisor_watchdog: digital core of a microprocessor supervisor
// assumes comparator results arrive as asynchronous logic levels and that the
// three-level strobe pin is pre-decoded into a level and a mid-supply flag
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/100ps

module supply_supervisor_watchdog #(
   parameter logic [31:0] HOLD_SHORT = supervisor_pkg::HOLD_SHORT_CYC,
   parameter logic [31:0] HOLD_LONG  = supervisor_pkg::HOLD_LONG_CYC,
   parameter logic [31:0] WDOG_SHORT = supervisor_pkg::WDOG_SHORT_CYC,
   parameter logic [31:0] WDOG_LONG  = supervisor_pkg::WDOG_LONG_CYC
) (
   // clock and reset
   input  wire logic                              core_clk_in,
   input  wire logic                              rstn_in,
   // apb slave
   input  wire logic                              psel_in,
   input  wire logic                              penable_in,
   input  wire logic                              pwrite_in,
   input  wire logic [supervisor_pkg::APB_AW-1:0] paddr_in,
   input  wire logic [31:0]                       pwdata_in,
   input  wire logic [3:0]                        pstrb_in,
   output logic      [31:0]                       prdata_out,
   output logic                                   pready_out,
   output logic                                   pslverr_out,
   // comparator results and host pins (asynchronous)
   input  wire logic                              supply_low_in,
   input  wire logic                              supply_below_batt_in,
   input  wire logic                              pf_compare_in,
   input  wire logic                              wdog_strobe_in,
   input  wire logic                              wdog_strobe_mid_in,
   input  wire logic                              ce_n_in,
   input  wire logic                              timebase_select_in,
   input  wire logic                              timebase_clk_in,
   // supervisor outputs
   output logic                                   rst_n_out,
   output logic                                   rst_out,
   output logic                                   wdog_timeout_out_n,
   output logic                                   pf_warn_n_out,
   output logic                                   ce_n_out,
   output logic                                   backup_active_out,
   output logic                                   low_line_n_out
);
   import supervisor_pkg::*;

   // synchroniser and edge history
   logic [NPINS-1:0] pin_s1_r;
   logic [NPINS-1:0] pin_s2_r;
   logic             tb_clk_d_r;
   logic             strobe_d_r;
   logic             mid_d_r;

   // sequencer and watchdog state
   rst_state_e       state_r;
   rst_state_e       state_nxt;
   logic [31:0]      hold_cnt_r;
   logic [31:0]      hold_cnt_nxt;
   logic [31:0]      wd_cnt_r;
   logic [31:0]      wd_cnt_nxt;
   logic             wdo_r;
   logic             wdo_nxt;

   // registered pin outputs
   logic             rst_n_r;
   logic             rst_r;
   logic             pf_warn_n_r;
   logic             pf_warn_n_nxt;
   logic             ce_n_r;
   logic             ce_n_nxt;
   logic             backup_r;
   logic             low_line_n_r;

   // apb state
   logic [1:0]       ctrl_r;
   logic [1:0]       ctrl_nxt;
   logic [31:0]      prdata_r;
   logic [31:0]      prdata_nxt;
   logic             pready_r;
   logic             pready_nxt;
   logic             pslverr_r;
   logic             pslverr_nxt;

   // decoded conditions
   logic             sel_ext;
   logic             tick;
   logic             supply_bad;
   logic             supply_low;
   logic             below_batt;
   logic             strobe_mid;
   logic             strobe_lvl;
   logic             transition;
   logic             wd_run;
   logic             wd_expire;
   logic [31:0]      hold_len;
   logic [31:0]      wd_len;
   logic [31:0]      status;

   // two-flop synchronisers, one per pin; stage one feeds only stage two
   genvar gi;
   generate
      for (gi = 0; gi < NPINS; gi++) begin : g_sync
         always_ff @(posedge core_clk_in or negedge rstn_in) begin
            if (!rstn_in) begin
               pin_s1_r[gi] <= PIN_RST[gi];
               pin_s2_r[gi] <= PIN_RST[gi];
            end else begin
               pin_s1_r[gi] <= pin_input(gi);
               pin_s2_r[gi] <= pin_s1_r[gi];
            end
         end
      end
   endgenerate

   // maps a synchroniser position to its pin
   function automatic logic pin_input(input int unsigned idx);
      logic v;
      v = 1'b0;
      case (idx)
         PIN_SUPPLY_LOW: v = supply_low_in;
         PIN_BELOW_BATT: v = supply_below_batt_in;
         PIN_PF_COMPARE: v = pf_compare_in;
         PIN_STROBE:     v = wdog_strobe_in;
         PIN_STROBE_MID: v = wdog_strobe_mid_in;
         PIN_CE_N:       v = ce_n_in;
         PIN_TB_SEL:     v = timebase_select_in;
         PIN_TB_CLK:     v = timebase_clk_in;
         default:        v = 1'b0;
      endcase
      return v;
   endfunction

   // timebase, strobe decode and interval selection
   always_comb begin
      supply_low = pin_s2_r[PIN_SUPPLY_LOW];
      below_batt = pin_s2_r[PIN_BELOW_BATT];
      supply_bad = supply_low | below_batt;
      sel_ext    = !pin_s2_r[PIN_TB_SEL];
      // external mode counts rising edges of the timebase pin
      tick       = sel_ext ? (pin_s2_r[PIN_TB_CLK] & !tb_clk_d_r) : 1'b1;
      // mid-supply is the inactive level; low and high are service levels
      strobe_mid = pin_s2_r[PIN_STROBE_MID];
      strobe_lvl = pin_s2_r[PIN_STROBE];
      transition = (strobe_lvl != strobe_d_r) | (strobe_mid != mid_d_r);
      if (sel_ext) begin
         hold_len = EXT_HOLD_TICKS;
         // external mode: short count only when software asks for it
         wd_len   = ctrl_r[CTRL_WDOG_SHORT_BIT] ? EXT_WDOG_SHORT_TICKS
                                                : EXT_WDOG_LONG_TICKS;
      end else begin
         hold_len = ctrl_r[CTRL_LONG_HOLD_BIT] ? HOLD_LONG : HOLD_SHORT;
         // timebase pin level picks the watchdog period
         wd_len   = pin_s2_r[PIN_TB_CLK] ? WDOG_LONG : WDOG_SHORT;
      end
      // the watchdog only runs on a good supply and an active strobe
      wd_run    = !strobe_mid && !supply_bad;
      wd_expire = wd_run && !transition && tick && (wd_cnt_r >= wd_len - 32'h0000_0001);
   end

   // watchdog counter and timeout flag
   always_comb begin
      wd_cnt_nxt = wd_cnt_r;
      wdo_nxt    = wdo_r;
      // restart on every transition, and after each expiry so that pulses repeat
      if (!wd_run || transition || wd_expire) begin
         wd_cnt_nxt = 32'h0000_0000;
      end else if (tick) begin
         wd_cnt_nxt = wd_cnt_r + 32'h0000_0001;
      end
      // release wins over expiry: a strobe edge means software is alive
      if (strobe_mid || supply_low || transition) begin
         wdo_nxt = 1'b1;
      end else if (wd_expire) begin
         wdo_nxt = 1'b0;
      end
   end

   // reset sequencer: power-bad, hold, run
   always_comb begin
      state_nxt    = state_r;
      hold_cnt_nxt = hold_cnt_r;
      case (state_r)
         RS_POWER_BAD: begin
            hold_cnt_nxt = 32'h0000_0000;
            if (!supply_bad) begin
               state_nxt = RS_HOLD;
            end
         end
         RS_HOLD: begin
            if (supply_bad) begin
               state_nxt = RS_POWER_BAD;
            end else if (tick) begin
               if (hold_cnt_r >= hold_len - 32'h0000_0001) begin
                  state_nxt    = RS_RUN;
                  hold_cnt_nxt = 32'h0000_0000;
               end else begin
                  hold_cnt_nxt = hold_cnt_r + 32'h0000_0001;
               end
            end
         end
         RS_RUN: begin
            if (supply_bad) begin
               state_nxt = RS_POWER_BAD;
            end else if (wd_expire) begin
               state_nxt    = RS_HOLD;
               hold_cnt_nxt = 32'h0000_0000;
            end
         end
         default: begin
            state_nxt    = RS_POWER_BAD;
            hold_cnt_nxt = 32'h0000_0000;
         end
      endcase
   end

   // output gating; outputs are registered so they lag the pins by three edges
   always_comb begin
      // below battery the comparator is ignored and the warning held low
      pf_warn_n_nxt = pin_s2_r[PIN_PF_COMPARE] & !below_batt;
      // chip select passes only while the supply is not low; below-battery does not gate it
      ce_n_nxt      = pin_s2_r[PIN_CE_N] | supply_low;
   end

   // core registers
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         tb_clk_d_r   <= 1'b0;
         strobe_d_r   <= 1'b0;
         mid_d_r      <= 1'b1;
         state_r      <= RS_POWER_BAD;
         hold_cnt_r   <= 32'h0000_0000;
         wd_cnt_r     <= 32'h0000_0000;
         wdo_r        <= 1'b1;
         rst_n_r      <= 1'b0;
         rst_r        <= 1'b1;
         pf_warn_n_r  <= 1'b0;
         ce_n_r       <= 1'b1;
         backup_r     <= 1'b0;
         low_line_n_r <= 1'b0;
      end else begin
         tb_clk_d_r   <= pin_s2_r[PIN_TB_CLK];
         strobe_d_r   <= strobe_lvl;
         mid_d_r      <= strobe_mid;
         state_r      <= state_nxt;
         hold_cnt_r   <= hold_cnt_nxt;
         wd_cnt_r     <= wd_cnt_nxt;
         wdo_r        <= wdo_nxt;
         // both reset polarities come from the same next state
         rst_n_r      <= (state_nxt == RS_RUN);
         rst_r        <= (state_nxt != RS_RUN);
         pf_warn_n_r  <= pf_warn_n_nxt;
         ce_n_r       <= ce_n_nxt;
         backup_r     <= below_batt;
         low_line_n_r <= !supply_low;
      end
   end

   // status word assembled from live state
   always_comb begin
      status                  = 32'h0000_0000;
      status[ST_RESET_BIT]    = !rst_n_r;
      status[ST_WDOG_TO_BIT]  = !wdo_r;
      status[ST_STROBE_MID]   = strobe_mid;
      status[ST_BACKUP_BIT]   = backup_r;
      status[ST_EXT_TB_BIT]   = sel_ext;
      status[ST_PF_WARN_BIT]  = !pf_warn_n_r;
      status[ST_STROBE_LVL]   = strobe_lvl;
   end

   // apb: answer is prepared in setup, so every access completes with no wait
   always_comb begin
      ctrl_nxt    = ctrl_r;
      pready_nxt  = psel_in & !penable_in;
      prdata_nxt  = 32'h0000_0000;
      pslverr_nxt = 1'b0;
      if (psel_in && !penable_in) begin
         if (paddr_in == CTRL_OFS) begin
            prdata_nxt = {30'h0000_0000, ctrl_r};
         end else if (paddr_in == STATUS_OFS) begin
            prdata_nxt = status;
         end else begin
            pslverr_nxt = 1'b1;                // unmapped or misaligned address
         end
         if (pwrite_in) begin
            prdata_nxt = 32'h0000_0000;
         end
      end
      // write lands only on the completing edge; status is read-only
      if (psel_in && penable_in && pready_r && pwrite_in && !pslverr_r
          && paddr_in == CTRL_OFS && pstrb_in[0]) begin
         ctrl_nxt = pwdata_in[1:0];
      end
   end

   // apb registers
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ctrl_r    <= CTRL_RST;
         prdata_r  <= 32'h0000_0000;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         ctrl_r    <= ctrl_nxt;
         prdata_r  <= prdata_nxt;
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   // outputs straight from flip-flops
   assign rst_n_out          = rst_n_r;
   assign rst_out            = rst_r;
   assign wdog_timeout_out_n = wdo_r;
   assign pf_warn_n_out      = pf_warn_n_r;
   assign ce_n_out           = ce_n_r;
   assign backup_active_out  = backup_r;
   assign low_line_n_out     = low_line_n_r;
   assign prdata_out         = prdata_r;
   assign pready_out         = pready_r;
   assign pslverr_out        = pslverr_r;

   // checks on the supervisor behaviour
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rstn_in);

   sequence wd_expire_s;
      wd_expire && state_r == RS_RUN;
   endsequence

   sequence reset_pulse_s;
      !rst_n_out [*2];
   endsequence

   supply_reset_a: assert property (supply_bad |=> !rst_n_out)
      else $error("reset not asserted on bad supply");

   reset_inverse_a: assert property (rst_out == !rst_n_out)
      else $error("reset outputs not complementary");

   wdog_pulse_a: assert property (wd_expire_s |=> reset_pulse_s)
      else $error("watchdog expiry gave no reset pulse");

   wdog_flag_a: assert property (wd_expire_s |=> !wdog_timeout_out_n)
      else $error("timeout output not low after expiry");

   strobe_mid_a: assert property (strobe_mid |=> wdog_timeout_out_n && wd_cnt_r == 32'h0)
      else $error("watchdog active with floating strobe");

   low_line_a: assert property (supply_low |=> wdog_timeout_out_n)
      else $error("timeout output not forced high on low line");

   wdo_hold_a: assert property (!wdog_timeout_out_n && !transition && !strobe_mid
      && !supply_low |=> !wdog_timeout_out_n)
      else $error("timeout output released without strobe transition");

   strobe_restart_a: assert property (transition |=> wd_cnt_r == 32'h0)
      else $error("strobe transition did not restart count");

   pf_warn_a: assert property (below_batt || !pin_s2_r[PIN_PF_COMPARE]
      |=> !pf_warn_n_out)
      else $error("power-fail warning not low");

   ce_gate_a: assert property (supply_low |=> ce_n_out)
      else $error("chip select passed on low supply");

   backup_flag_a: assert property (##1 backup_active_out == $past(below_batt))
      else $error("backup-active output wrong");

   hold_release_a: assert property (state_r == RS_HOLD && $past(state_r) == RS_POWER_BAD
      |-> !rst_n_out ##1 !rst_n_out)
      else $error("reset released without hold interval");

endmodule // supply_supervisor_watchdog

//--- verif/host_cpu_model.sv
// host_cpu_model: host side of the three-level watchdog strobe
// assumes it shares the supervisor core clock; bench sets pace
`timescale 1ns/100ps
module host_cpu_model (
   // clock and reset
   input  wire logic       clk_in,
   input  wire logic       rstn_in,
   // pacing from the bench
   input  wire logic       run_in,
   input  wire logic       kick_in,
   input  wire logic       float_in,
   input  wire logic [7:0] gap_in,
   // decoded strobe pin
   output logic            strobe_out,
   output logic            strobe_mid_out
);
   logic [7:0] cnt_r;

   // a released pin wanders every cycle, so no stale level looks valid
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cnt_r          <= 8'h00;
         strobe_out     <= 1'b0;
         strobe_mid_out <= 1'b1;
      end else begin
         strobe_mid_out <= float_in;
         cnt_r          <= (run_in && cnt_r < gap_in) ? cnt_r + 8'h01 : 8'h00;
         if (float_in || kick_in || (run_in && cnt_r >= gap_in)) begin
            strobe_out <= ~strobe_out;
         end
      end
   end
endmodule // host_cpu_model

//--- verif/test_supply_supervisor_watchdog.sv
// test_supply_supervisor_watchdog: self-checking bench for the supervisor
// assumes shortened hold and timeout counts; apb and pins driven here
`timescale 1ns/100ps
module test_supply_supervisor_watchdog;
   import supervisor_pkg::*;
   localparam int HS = 20;
   localparam int HL = 40;
   localparam int WS = 100;
   localparam int WL = 200;
   logic        core_clk_in, rstn_in, psel_in, penable_in, pwrite_in;
   logic [11:0] paddr_in;
   logic [31:0] pwdata_in, prdata_out, seed;
   logic [3:0]  pstrb_in;
   logic        pready_out, pslverr_out, supply_low_in, supply_below_batt_in;
   logic        pf_compare_in, wdog_strobe_in, wdog_strobe_mid_in, ce_n_in;
   logic        timebase_select_in, timebase_clk_in, rst_n_out, rst_out;
   logic        wdog_timeout_out_n, pf_warn_n_out, ce_n_out, backup_active_out;
   logic        low_line_n_out, run, kick, flt;
   logic [7:0]  gap;
   logic [32:0] rd_q[$];
   logic [6:0]  ex_q[$];
   int          fail_count, n_compared;

   supply_supervisor_watchdog #(.HOLD_SHORT(32'(HS)), .HOLD_LONG(32'(HL)),
      .WDOG_SHORT(32'(WS)), .WDOG_LONG(32'(WL))) i_dut (
      .core_clk_in, .rstn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
      .pwdata_in, .pstrb_in, .prdata_out, .pready_out, .pslverr_out,
      .supply_low_in, .supply_below_batt_in, .pf_compare_in, .wdog_strobe_in,
      .wdog_strobe_mid_in, .ce_n_in, .timebase_select_in, .timebase_clk_in,
      .rst_n_out, .rst_out, .wdog_timeout_out_n, .pf_warn_n_out, .ce_n_out,
      .backup_active_out, .low_line_n_out);

   host_cpu_model i_host (.clk_in(core_clk_in), .rstn_in(rstn_in), .run_in(run),
      .kick_in(kick), .float_in(flt), .gap_in(gap), .strobe_out(wdog_strobe_in),
      .strobe_mid_out(wdog_strobe_mid_in));

   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_in);
   endtask

   // host-supplied external timebase: one pin toggle per core cycle, a tick every two
   task automatic ext_run(input int n);
      repeat (n) begin
         timebase_clk_in <= ~timebase_clk_in;
         @(posedge core_clk_in);
      end
   endtask

   // expected pins; active-high reset is always noted as the inverse
   task automatic ex(input logic rn, wd, pf, ce, bt, ll);
      ex_q.push_back({rn, ~rn, wd, pf, ce, bt, ll});
   endtask

   // one apb transfer; waits for pready without assuming a latency
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] e);
      if (!w) rd_q.push_back(e);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge core_clk_in);
      penable_in <= 1'b1;
      @(posedge core_clk_in);
      // only the bench watchdog ends a wait that never sees pready
      while (pready_out !== 1'b1) @(posedge core_clk_in);
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge core_clk_in);
   endtask

   task automatic cmp(input logic [32:0] g, input logic [32:0] e);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // monitor on the falling edge, where every output has settled
   always @(negedge core_clk_in) begin
      if (ex_q.size() > 0) cmp(33'({rst_n_out, rst_out, wdog_timeout_out_n,
         pf_warn_n_out, ce_n_out, backup_active_out, low_line_n_out}),
         33'(ex_q.pop_front()));
   end

   // read data is taken at the very edge that samples pready high
   always @(posedge core_clk_in) begin
      if (psel_in && penable_in && pready_out && !pwrite_in && rd_q.size() > 0)
         cmp({pslverr_out, prdata_out}, rd_q.pop_front());
   end

   // clock
   initial begin
      core_clk_in = 1'b0;
      forever #4 core_clk_in = ~core_clk_in;
   end

   // hang guard, far beyond the few thousand cycles the sequence needs
   initial begin
      #200000;
      fail_count++;
      $display("MISMATCH t=%0t watchdog ran out", $time);
      wrap_up();
   end

   // main sequence
   initial begin
      {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
      {supply_low_in, pf_compare_in, timebase_select_in, timebase_clk_in} = 4'hf;
      {supply_below_batt_in, ce_n_in, run, kick, flt} = 5'h01;
      pstrb_in = 4'hf;
      gap = 8'h20;
      seed = 32'(45559);
      fail_count = 0;
      n_compared = 0;
      rstn_in = 1'b0;
      tick(6);
      rstn_in <= 1'b1;
      tick(5);
      ex(0, 1, 1, 1, 0, 0);
      supply_low_in <= 1'b0;
      tick(10);
      ex(0, 1, 1, 0, 0, 1);
      tick(HS);
      ex(1, 1, 1, 0, 0, 1);
      pf_compare_in <= 1'b0;
      tick(5);
      ex(1, 1, 0, 0, 0, 1);
      pf_compare_in <= 1'b1;
      supply_below_batt_in <= 1'b1;
      tick(5);
      ex(0, 1, 0, 0, 1, 1);
      supply_below_batt_in <= 1'b0;
      tick(HS + 10);
      ex(1, 1, 1, 0, 0, 1);
      apb(1'b1, CTRL_OFS, 32'h0000_0001, '0);
      apb(1'b0, CTRL_OFS, '0, 33'h0_0000_0001);
      apb(1'b0, 12'h008, '0, 33'h1_0000_0000);
      supply_low_in <= 1'b1;
      tick(5);
      supply_low_in <= 1'b0;
      tick(HL - 5);
      ex(0, 1, 1, 0, 0, 1);
      tick(20);
      ex(1, 1, 1, 0, 0, 1);
      apb(1'b1, CTRL_OFS, 32'h0000_0000, '0);
      // serviced at random paces, never a reset
      flt <= 1'b0;
      run <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         gap <= 8'(20 + seed % 150);
         tick(100);
         ex(1, 1, 1, 0, 0, 1);
      end
      // strobe stuck: pulses repeat, timeout held until a transition
      run <= 1'b0;
      kick <= 1'b1;
      tick(1);
      kick <= 1'b0;
      tick(WL - 12);
      ex(1, 1, 1, 0, 0, 1);
      tick(25);
      ex(0, 0, 1, 0, 0, 1);
      tick(26);
      ex(1, 0, 1, 0, 0, 1);
      tick(WL - 30);
      ex(0, 0, 1, 0, 0, 1);
      kick <= 1'b1;
      tick(1);
      kick <= 1'b0;
      tick(7);
      ex(0, 1, 1, 0, 0, 1);
      tick(20);
      ex(1, 1, 1, 0, 0, 1);
      flt <= 1'b1;
      tick(2 * WL + 50);
      ex(1, 1, 1, 0, 0, 1);
      // short timeout picked by the timebase pin level
      timebase_clk_in <= 1'b0;
      flt <= 1'b0;
      tick(WS - 5);
      ex(1, 1, 1, 0, 0, 1);
      tick(15);
      ex(0, 0, 1, 0, 0, 1);
      supply_low_in <= 1'b1;
      tick(5);
      ex(0, 1, 1, 1, 0, 0);
      supply_low_in <= 1'b0;
      flt <= 1'b1;
      tick(HS + 20);
      ex(1, 1, 1, 0, 0, 1);
      // chip select input high must keep the gated output high
      ce_n_in <= 1'b1;
      tick(5);
      ex(1, 1, 1, 1, 0, 1);
      ce_n_in <= 1'b0;
      // external timebase, short count chosen by software, strobe held still
      apb(1'b1, CTRL_OFS, 32'h0000_0002, '0);
      timebase_select_in <= 1'b0;
      flt <= 1'b0;
      ext_run(2 * int'(EXT_WDOG_SHORT_TICKS) - 8);
      ex(1, 1, 1, 0, 0, 1);
      ext_run(20);
      ex(0, 0, 1, 0, 0, 1);
      ext_run(2 * int'(EXT_HOLD_TICKS) - 20);
      ex(0, 0, 1, 0, 0, 1);
      ext_run(25);
      ex(1, 0, 1, 0, 0, 1);
      tick(2);
      wrap_up();
   end
endmodule // test_supply_supervisor_watchdog
